// ---- pkg/ohi_pkg.sv ----
// Constants, state codes and mode decoding for the host interface select block.
// Assumes one synchronous clock domain and pins already synchronous to it.
package ohi_pkg;
  localparam int unsigned DATA_W = 18;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam logic [7:0] CMD_IFACE_SEL = 8'h36;
  localparam int unsigned PARAM_LSB = 0;
  localparam logic [1:0] HI_RESET = 2'h0;
  localparam logic [3:0] SEL_SPI4 = 4'h0;
  localparam logic [3:0] SEL_SPI3 = 4'h1;
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_18 = 2'h3;
  localparam logic [17:0] MASK_8 = 18'h000ff;
  localparam logic [17:0] MASK_16 = 18'h0ffff;
  localparam logic [17:0] MASK_18 = 18'h3ffff;
  localparam logic [3:0] SER4_BITS = 4'h8;
  localparam logic [3:0] SER3_BITS = 4'h9;
  localparam int unsigned SCLK_BIT = 0;
  localparam int unsigned SDIN_BIT = 1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WR = 2'b01,
    ST_RD = 2'b10
  } ohi_state_t;

  // Legal interface codes only
  function automatic logic sel_ok(input logic [3:0] sel);
    if (!sel[1])
      return (sel == SEL_SPI4) || (sel == SEL_SPI3);
    return (sel[3:2] == WIDTH_8) || (sel[3:2] == WIDTH_16) || (sel[3:2] == WIDTH_18);
  endfunction

  // Data lines in use for a parallel width
  function automatic logic [17:0] width_mask(input logic [3:0] sel);
    unique case (sel[3:2])
      WIDTH_8: return MASK_8;
      WIDTH_16: return MASK_16;
      default: return MASK_18;
    endcase
  endfunction
endpackage

// ---- hw/ohi_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an active-low reset already synchronised.
`timescale 1ns/1ns
module ohi_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic wr, rd;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rp_q];

  always_comb
  begin
    wr = in_valid && in_ready;
    rd = out_valid && out_ready;
    wp_d = wr ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = rd ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = (AW+1)'(cnt_q + wr - rd);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (wr)
      mem[wp_q] <= in_data;
  end
endmodule

// ---- hw/ohi_host_port.sv ----
// Host port of a display driver: interface select, strobe decode, word routing.
// Assumes host pins synchronous to clk; bus wire resolved outside from enables.
//
// Functional notes
// RULE1 - A four-bit select picks 4-wire or 3-wire serial, or 6800/8080 at 8, 16 or 18 bits.
// RULE2 - The two low select bits are pins and the two high bits are set by command 0x36.
// RULE3 - In 6800 mode a transfer begins while enable is high and chip select is low.
// RULE4 - In 6800 mode direction high means read and low means write.
// RULE5 - In 8080 mode a read starts when the read strobe is low with chip select low.
// RULE6 - In 8080 mode a write starts when the write strobe is low with chip select low.
// RULE7 - In serial modes the host ties both strobe inputs low.
// RULE8 - A word goes to display data when data/command is high, else to the command register.
// RULE9 - The chip initialises while the active-low init input is low.
// RULE10 - The host bus is served only while chip select is low.
// RULE11 - The 18-bit data bus is driven during reads and sampled during writes.
// RULE12 - The host sends the parameters of command 0x36 as data words.
// RULE13 - In 8-bit and 16-bit modes unused upper lines are ignored and never driven.
`timescale 1ns/1ns
module ohi_host_port #(
  parameter int unsigned DEPTH = ohi_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chip_init_low,
  // Host pins
  input wire logic cs_b,
  input wire logic e_rd,
  input wire logic rw_wr,
  input wire logic dc,
  input wire logic iface_select_bit0,
  input wire logic iface_select_bit1,
  input wire logic [17:0] host_data_in,
  output logic [17:0] host_data_out_q,
  output logic [17:0] host_data_oe_q,
  // Read-back word from the display side
  input wire logic [17:0] rd_data,
  // Command register
  output logic [7:0] cmd_q,
  output logic cmd_stb_q,
  // Display data stream
  output logic pix_valid,
  input wire logic pix_ready,
  output logic [17:0] pix_data,
  // Status
  output logic [1:0] sel_hi_q,
  output logic init_busy_q,
  output logic busy_q
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  ohi_pkg::ohi_state_t st_q, st_d;
  logic [17:0] wbuf_q, wbuf_d, dout_d, oe_d, mask, mask_q;
  logic [8:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d, nbits;
  logic sclk_q, sclk_d, stb_d, wait_q, wait_d, busy_d, init_d;
  logic [7:0] cmd_d;
  logic [1:0] hi_d;
  logic [3:0] sel;
  logic ok, par, m68, push, push_dc, fifo_ready;
  logic [17:0] push_word;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb
  begin
    sel = {sel_hi_q, iface_select_bit1, iface_select_bit0}; // see RULE2
    ok = ohi_pkg::sel_ok(sel); // see RULE1
    par = sel[1];
    m68 = sel[0];
    mask = ohi_pkg::width_mask(sel); // see RULE13
    nbits = m68 ? ohi_pkg::SER3_BITS : ohi_pkg::SER4_BITS;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine
  always_comb
  begin
    st_d = st_q;
    wbuf_d = wbuf_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    sclk_d = host_data_in[ohi_pkg::SCLK_BIT];
    oe_d = '0;
    dout_d = host_data_out_q;
    cmd_d = cmd_q;
    stb_d = 1'b0;
    hi_d = sel_hi_q;
    wait_d = wait_q;
    push = 1'b0;
    push_dc = 1'b0;
    push_word = '0;
    busy_d = !fifo_ready;
    init_d = 1'b0;
    // Parallel strobes
    if (cs_b || !ok || !par) // see RULE10
      st_d = ohi_pkg::ST_IDLE;
    else
    begin
      unique case (st_q)
        ohi_pkg::ST_IDLE:
        begin
          if (m68 && e_rd) // see RULE3
            st_d = rw_wr ? ohi_pkg::ST_RD : ohi_pkg::ST_WR; // see RULE4
          else if (!m68 && !e_rd) // see RULE5
            st_d = ohi_pkg::ST_RD;
          else if (!m68 && !rw_wr) // see RULE6
            st_d = ohi_pkg::ST_WR;
          wbuf_d = host_data_in & mask; // see RULE11
        end
        ohi_pkg::ST_WR:
        begin
          if (m68 ? !e_rd : rw_wr)
          begin
            push = 1'b1;
            push_dc = dc;
            push_word = wbuf_q;
            st_d = ohi_pkg::ST_IDLE;
          end
          else
            wbuf_d = host_data_in & mask; // see RULE13
        end
        ohi_pkg::ST_RD:
        begin
          if (m68 ? !e_rd : e_rd)
            st_d = ohi_pkg::ST_IDLE;
        end
        default: st_d = ohi_pkg::ST_IDLE;
      endcase
    end
    // Serial shifter, strobe pins held low by the host
    if (cs_b || !ok || par) // see RULE7
      cnt_d = '0;
    else if (host_data_in[ohi_pkg::SCLK_BIT] && !sclk_q)
    begin
      sh_d = {sh_q[7:0], host_data_in[ohi_pkg::SDIN_BIT]};
      cnt_d = 4'(cnt_q + 1'b1);
      if (cnt_d == nbits)
      begin
        cnt_d = '0;
        push = 1'b1;
        push_dc = m68 ? sh_d[8] : dc;
        push_word = {10'h000, sh_d[7:0]};
      end
    end
    // Routing
    if (push && !push_dc) // see RULE8
    begin
      cmd_d = push_word[7:0];
      stb_d = 1'b1;
      wait_d = (push_word[7:0] == ohi_pkg::CMD_IFACE_SEL);
    end
    else if (push && wait_q) // see RULE12
    begin
      hi_d = push_word[ohi_pkg::PARAM_LSB +: 2]; // see RULE2
      wait_d = 1'b0;
    end
    if (st_d == ohi_pkg::ST_RD) // see RULE11
    begin
      oe_d = mask; // see RULE13
      dout_d = rd_data & mask;
    end
    if (!chip_init_low) // see RULE9
    begin
      st_d = ohi_pkg::ST_IDLE;
      cnt_d = '0;
      oe_d = '0;
      stb_d = 1'b0;
      hi_d = ohi_pkg::HI_RESET;
      wait_d = 1'b0;
      init_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ohi_pkg::ST_IDLE;
      wbuf_q <= '0;
      sh_q <= '0;
      cnt_q <= '0;
      sclk_q <= 1'b0;
      host_data_out_q <= '0;
      host_data_oe_q <= '0;
      mask_q <= '0;
      cmd_q <= '0;
      cmd_stb_q <= 1'b0;
      sel_hi_q <= ohi_pkg::HI_RESET;
      wait_q <= 1'b0;
      busy_q <= 1'b0;
      init_busy_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      wbuf_q <= wbuf_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      sclk_q <= sclk_d;
      host_data_out_q <= dout_d;
      host_data_oe_q <= oe_d;
      mask_q <= mask;
      cmd_q <= cmd_d;
      cmd_stb_q <= stb_d;
      sel_hi_q <= hi_d;
      wait_q <= wait_d;
      busy_q <= busy_d;
      init_busy_q <= init_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Display data buffer
  ohi_fifo #(
    .WIDTH(ohi_pkg::DATA_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push && push_dc && chip_init_low), // see RULE8
    .in_ready(fifo_ready),
    .in_data(push_word),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_cs_quiet;
    cs_b |=> !cmd_stb_q && (host_data_oe_q == '0);
  endproperty
  a_cs_quiet: assert property (p_cs_quiet) else $error("bus served without select"); // see RULE10

  property p_rd_only;
    (host_data_oe_q != '0) |-> $past(st_d == ohi_pkg::ST_RD);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("bus driven outside read"); // see RULE11

  property p_upper_quiet;
    (host_data_oe_q & ~mask_q) == '0;
  endproperty
  a_upper_quiet: assert property (p_upper_quiet) else $error("unused lines driven"); // see RULE13

  property p_cmd_route;
    push && chip_init_low |=> cmd_stb_q == !$past(push_dc);
  endproperty
  a_cmd_route: assert property (p_cmd_route) else $error("word misrouted"); // see RULE8

  property p_hi_src;
    !$stable(sel_hi_q) && $past(chip_init_low) |-> $past(push && push_dc && wait_q);
  endproperty
  a_hi_src: assert property (p_hi_src) else $error("select bits moved alone"); // see RULE2

  property p_init;
    !chip_init_low |=> init_busy_q && sel_hi_q == ohi_pkg::HI_RESET && st_q == ohi_pkg::ST_IDLE;
  endproperty
  a_init: assert property (p_init) else $error("init not applied"); // see RULE9

  sequence s_go;
    chip_init_low && !cs_b && ok && par && st_q == ohi_pkg::ST_IDLE;
  endsequence

  property p_m68;
    s_go and m68 && e_rd |=> st_q == ($past(rw_wr) ? ohi_pkg::ST_RD : ohi_pkg::ST_WR);
  endproperty
  a_m68: assert property (p_m68) else $error("6800 start wrong"); // see RULE3

  property p_m68_dir;
    s_go and m68 && e_rd && rw_wr |=> host_data_oe_q != '0;
  endproperty
  a_m68_dir: assert property (p_m68_dir) else $error("6800 read not driven"); // see RULE4

  property p_i80_rd;
    s_go and !m68 && !e_rd |=> st_q == ohi_pkg::ST_RD;
  endproperty
  a_i80_rd: assert property (p_i80_rd) else $error("8080 read missed"); // see RULE5

  property p_i80_wr;
    s_go and !m68 && e_rd && !rw_wr |=> st_q == ohi_pkg::ST_WR;
  endproperty
  a_i80_wr: assert property (p_i80_wr) else $error("8080 write missed"); // see RULE6

  c_read: cover property (st_q == ohi_pkg::ST_RD ##1 st_q == ohi_pkg::ST_IDLE);
  c_cmd: cover property (cmd_stb_q && cmd_q == ohi_pkg::CMD_IFACE_SEL);
  c_serial: cover property (push && !par);
  c_full: cover property (busy_q);
endmodule

// ---- test/ohi_host_model.sv ----
// Host microcontroller model driving the host pins in 6800, 8080 or serial style.
// Assumes the bench resolves the shared data wire from both enables.
`timescale 1ns/1ns
module ohi_host_model (
  // Clock and bus view
  input wire logic clk,
  input wire logic [17:0] bus,
  input wire logic [17:0] dev_oe,
  // Host pins
  output logic cs_b,
  output logic e_rd,
  output logic rw_wr,
  output logic dc,
  output logic [17:0] hd,
  output logic hoe,
  // Last read capture
  output logic [17:0] seen_d,
  output logic [17:0] seen_oe
);
  initial
  begin
    cs_b = 1'b1;
    dc = 1'b0;
    hd = 18'h0;
    hoe = 1'b0;
    idle(2'h0);
  end

  // Idle strobes: 0 is 8080, 1 is 6800, 2 is serial
  task automatic idle(input logic [1:0] m);
    e_rd = (m == 2'h0);
    rw_wr = (m == 2'h0);
  endtask

  // Same pin pattern opens both styles of write; n sets the strobe length
  task automatic wr(input logic m6800, input logic sel_b, input logic d_c,
                    input logic [17:0] w, input int n);
    @(negedge clk);
    cs_b = sel_b;
    dc = d_c;
    hd = w;
    hoe = 1'b1;
    e_rd = 1'b1;
    rw_wr = 1'b0;
    repeat (n) @(negedge clk);
    e_rd = !m6800;
    rw_wr = !m6800;
    @(negedge clk);
    cs_b = 1'b1;
    hoe = 1'b0;
  endtask

  task automatic rd(input logic m6800, input int n);
    @(negedge clk);
    cs_b = 1'b0;
    e_rd = m6800;
    rw_wr = 1'b1;
    repeat (n) @(negedge clk);
    seen_d = bus;
    seen_oe = dev_oe;
    e_rd = !m6800;
    @(negedge clk);
    cs_b = 1'b1;
  endtask

  // Serial clock on line 0 rests low, data on line 1 MSB first
  task automatic ser(input int nb, input logic d_c, input logic [8:0] w);
    @(negedge clk);
    cs_b = 1'b0;
    dc = d_c;
    hoe = 1'b1;
    hd = 18'h0;
    for (int i = nb - 1; i >= 0; i--)
    begin
      @(negedge clk);
      hd = {16'h0, w[i], 1'b0};
      @(negedge clk);
      hd[0] = 1'b1;
    end
    @(negedge clk);
    hd[0] = 1'b0;
    cs_b = 1'b1;
    hoe = 1'b0;
  endtask
endmodule

// ---- test/oled_host_interface_select_bench.sv ----
// Self-checking bench for the host port with a host model on the pins.
// Assumes the design package is compiled first.
`timescale 1ns/1ns
module oled_host_interface_select_bench;
  logic clk, rst_b, chip_init_low, sel0, sel1, pix_ready;
  logic cs_b, e_rd, rw_wr, dc, hoe, cmd_stb_q, pix_valid, init_busy_q, busy_q;
  logic [17:0] bus, hd, d_out, d_oe, rd_data, pix_data;
  logic [7:0] cmd_q;
  logic [1:0] sel_hi_q;
  int num_errors = 0;
  int n_tests = 0;

  // Released host lines show the inverse of their last value
  assign bus = (d_oe & d_out) | (~d_oe & (hoe ? hd : ~hd));

  ohi_host_port dut_u (.clk(clk), .rst_b(rst_b), .chip_init_low(chip_init_low),
    .cs_b(cs_b), .e_rd(e_rd), .rw_wr(rw_wr), .dc(dc), .iface_select_bit0(sel0),
    .iface_select_bit1(sel1), .host_data_in(bus), .host_data_out_q(d_out),
    .host_data_oe_q(d_oe), .rd_data(rd_data), .cmd_q(cmd_q), .cmd_stb_q(cmd_stb_q),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
    .sel_hi_q(sel_hi_q), .init_busy_q(init_busy_q), .busy_q(busy_q));

  ohi_host_model host_u (.clk(clk), .bus(bus), .dev_oe(d_oe), .cs_b(cs_b), .e_rd(e_rd),
    .rw_wr(rw_wr), .dc(dc), .hd(hd), .hoe(hoe), .seen_d(), .seen_oe());

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [17:0] got, input logic [17:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic await(input logic pix);
    for (int i = 0; i < 20; i++)
    begin
      if ((pix ? pix_valid : cmd_stb_q) === 1'b1)
        return;
      @(negedge clk);
    end
    chk("handshake", 18'h0, 18'h1);
    test_done();
  endtask

  task automatic pop(input logic [17:0] exp);
    await(1'b1);
    chk("pix_data", pix_data, exp);
    pix_ready = 1'b1;
    @(negedge clk);
    pix_ready = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cmd;
    host_u.wr(1'b0, 1'b0, 1'b0, 18'h000a5, 1);
    await(1'b0);
    chk("cmd_q", {10'h0, cmd_q}, 18'h000a5);
    host_u.wr(1'b0, 1'b1, 1'b0, 18'h0005a, 1);
    repeat (3) @(negedge clk);
    chk("cmd_q", {10'h0, cmd_q}, 18'h000a5);
    $display("Test cmd done");
  endtask

  task automatic t_fifo;
    for (int i = 0; i < 17; i++)
      host_u.wr(1'b0, 1'b0, 1'b1, 18'h3ff00 | 18'(i), 2);
    chk("busy_q", {17'h0, busy_q}, 18'h1);
    for (int i = 0; i < 16; i++)
      pop(18'(i));
    chk("pix_valid", {17'h0, pix_valid}, 18'h0);
    $display("Test fifo done");
  endtask

  task automatic t_sel;
    host_u.wr(1'b0, 1'b0, 1'b0, 18'h00036, 1);
    host_u.wr(1'b0, 1'b0, 1'b1, 18'h00003, 1);
    pop(18'h00003);
    chk("sel_hi_q", {16'h0, sel_hi_q}, 18'h3);
    sel0 = 1'b1;
    host_u.idle(2'h1);
    host_u.wr(1'b1, 1'b0, 1'b1, 18'h2aaaa, 2);
    pop(18'h2aaaa);
    rd_data = 18'h15555;
    host_u.rd(1'b1, 3);
    chk("oe", host_u.seen_oe, 18'h3ffff);
    chk("bus", host_u.seen_d, 18'h15555);
    sel0 = 1'b0;
    host_u.idle(2'h0);
    rd_data = 18'h0abcd;
    host_u.rd(1'b0, 2);
    chk("bus", host_u.seen_d, 18'h0abcd);
    host_u.wr(1'b0, 1'b0, 1'b0, 18'h00036, 1);
    host_u.wr(1'b0, 1'b0, 1'b1, 18'h00001, 1);
    pop(18'h00001);
    chk("sel_hi_q", {16'h0, sel_hi_q}, 18'h1);
    host_u.rd(1'b0, 2);
    chk("oe", host_u.seen_oe, 18'h0ffff);
    chk("bus", host_u.seen_d & 18'h0ffff, 18'h0abcd);
    host_u.wr(1'b0, 1'b0, 1'b0, 18'h00036, 1);
    host_u.wr(1'b0, 1'b0, 1'b1, 18'h00000, 1);
    pop(18'h00000);
    rd_data = 18'h3ffff;
    host_u.rd(1'b0, 2);
    chk("oe", host_u.seen_oe, 18'h000ff);
    chk("bus", host_u.seen_d & 18'h000ff, 18'h000ff);
    $display("Test select done");
  endtask

  task automatic t_ser;
    sel1 = 1'b0;
    host_u.idle(2'h2);
    host_u.ser(8, 1'b0, 9'h0c3);
    await(1'b0);
    chk("cmd_q", {10'h0, cmd_q}, 18'h000c3);
    host_u.ser(8, 1'b1, 9'h081);
    pop(18'h00081);
    sel0 = 1'b1;
    host_u.ser(9, 1'b1, 9'h03c);
    await(1'b0);
    chk("cmd_q", {10'h0, cmd_q}, 18'h0003c);
    $display("Test serial done");
  endtask

  task automatic t_init;
    chip_init_low = 1'b0;
    repeat (3) @(negedge clk);
    chk("init_busy_q", {17'h0, init_busy_q}, 18'h1);
    chip_init_low = 1'b1;
    repeat (3) @(negedge clk);
    chk("init_busy_q", {17'h0, init_busy_q}, 18'h0);
    $display("Test init done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst_b = 1'b0;
    chip_init_low = 1'b1;
    sel1 = 1'b1;
    sel0 = 1'b0;
    rd_data = 18'h0;
    pix_ready = 1'b0;
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    t_cmd();
    t_fifo();
    t_sel();
    t_ser();
    t_init();
    test_done();
  end
endmodule
